// ---- rtl/i2c_page_writer.v ----
// Purpose: transmit side of an i2c master running eeprom page writes
// Assumes: firmware writes bytes via tx_write; one clock domain
// Notes: writes queue in a fifo; empty flag means queue and shifter idle
`timescale 1ns/10ps
`include "i2c_tx_defines.vh"
// Overview of operation
// - write to data register clears empty flag
// - loaded byte is shifted out on sda
// - byte done: set empty flag if the queue is empty, pulse interrupt
// - stop bit set: stop after the byte
// - stop ends the whole page transfer
// - stop bit clear: bus stays held
// - start then slave address register first
module i2c_page_writer #(
    parameter QUARTER = `QUARTER_CYCLES,
    parameter DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // firmware side
    input wire tx_write,
    input wire [7:0] transmit_data_register,
    input wire [7:0] slave_address_register,
    input wire stop_after_write_bit,
    output reg transmit_empty_flag,
    output reg tx_irq,
    output reg nack_seen,
    output reg bus_busy,
    // i2c pins
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe
);
    localparam S_IDLE = 3'd0;
    localparam S_START = 3'd1;
    localparam S_BIT = 3'd2;
    localparam S_ACK = 3'd3;
    localparam S_NEXT = 3'd4;
    localparam S_STOP = 3'd5;

    reg [2:0] state_reg;
    reg [1:0] phase_reg;
    reg [15:0] tick_reg;
    reg [3:0] bit_reg;
    reg [7:0] shift_reg;
    reg addr_sent_reg;
    reg open_reg;
    reg stop_reg;
    reg [8:0] cur_reg;
    reg [2:0] sda_sync_reg;
    reg sda_level_reg;
    wire fifo_in_ready;
    wire fifo_valid;
    wire [8:0] fifo_data;
    reg fifo_pop;
    wire tick;
    wire sda_now;
    wire flag_on_done;

    // three stage sync; a new level counts once second and third agree,
    // otherwise the last agreed level is held so a glitch is not a nack
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sda_sync_reg <= 3'b111;
            sda_level_reg <= 1'b1;
        end else begin
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            if (sda_sync_reg[2] == sda_sync_reg[1]) begin
                sda_level_reg <= sda_sync_reg[2];
            end
        end
    end
    assign sda_now = sda_level_reg;

    // queue holds the byte plus its stop bit, sampled at write time
    tx_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(DEPTH), .AW(5)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(tx_write),
        .in_ready(fifo_in_ready),
        .in_data({stop_after_write_bit, transmit_data_register}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    assign tick = (tick_reg == QUARTER - 1);

    // a completion leaves the flag low while writes still wait in the queue
    assign flag_on_done = ~tx_write & ~fifo_valid;

    // quarter bit timer, free running while the engine is out of S_IDLE
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_reg <= 16'h0000;
        end else if (state_reg == S_IDLE || tick) begin
            tick_reg <= 16'h0000;
        end else begin
            tick_reg <= tick_reg + 16'h0001;
        end
    end

    always @* begin
        fifo_pop = (state_reg == S_IDLE || state_reg == S_NEXT) && fifo_valid
                   && !(state_reg == S_NEXT && !tick);
    end

    // bit engine: four quarters per bit, scl high in quarter 2 only
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            phase_reg <= 2'd0;
            bit_reg <= 4'd0;
            shift_reg <= 8'h00;
            addr_sent_reg <= 1'b0;
            open_reg <= 1'b0;
            stop_reg <= 1'b0;
            cur_reg <= 9'h000;
            scl_out <= 1'b1;
            scl_oe <= 1'b0;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
            transmit_empty_flag <= `STAT_TXE_RESET;
            tx_irq <= 1'b0;
            nack_seen <= 1'b0;
            bus_busy <= 1'b0;
        end else begin
            tx_irq <= 1'b0;
            bus_busy <= open_reg | (state_reg != S_IDLE);
            if (tx_write) begin
                transmit_empty_flag <= 1'b0;
            end
            case (state_reg)
            S_IDLE: begin
                if (fifo_valid) begin
                    cur_reg <= fifo_data;
                    // start plus address only when no frame is held
                    if (!open_reg) begin
                        shift_reg <= slave_address_register;
                        addr_sent_reg <= 1'b0;
                        state_reg <= S_START;
                    end else begin
                        shift_reg <= fifo_data[7:0];
                        addr_sent_reg <= 1'b1;
                        state_reg <= S_BIT;
                    end
                    phase_reg <= 2'd0;
                    bit_reg <= 4'd0;
                end
            end
            S_START: if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                // sda falls while scl high, then scl drops
                case (phase_reg)
                2'd0: begin scl_out <= 1'b1; scl_oe <= 1'b1;
                      sda_out <= 1'b1; sda_oe <= 1'b1; end
                2'd1: sda_out <= 1'b0;
                2'd2: scl_out <= 1'b0;
                default: begin open_reg <= 1'b1; state_reg <= S_BIT; end
                endcase
            end
            S_BIT: if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                case (phase_reg)
                2'd0: begin sda_oe <= 1'b1;
                      sda_out <= shift_reg[7]; end
                2'd1: scl_out <= 1'b1;
                2'd2: scl_out <= 1'b0;
                default: begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    bit_reg <= bit_reg + 4'd1;
                    if (bit_reg == 4'd7) state_reg <= S_ACK;
                end
                endcase
            end
            S_ACK: if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                // release sda so the slave can pull it low
                case (phase_reg)
                2'd0: sda_oe <= 1'b0;
                2'd1: scl_out <= 1'b1;
                2'd2: begin scl_out <= 1'b0;
                      if (sda_now) nack_seen <= 1'b1; end
                default: begin
                    bit_reg <= 4'd0;
                    if (!addr_sent_reg) begin
                        addr_sent_reg <= 1'b1;
                        shift_reg <= cur_reg[7:0];
                        state_reg <= S_BIT;
                    end else if (cur_reg[8]) begin
                        state_reg <= S_STOP;
                    end else begin
                        // hold scl low and keep the frame open
                        transmit_empty_flag <= flag_on_done;
                        tx_irq <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                endcase
            end
            S_STOP: if (tick) begin
                phase_reg <= phase_reg + 2'd1;
                // sda rises while scl high
                case (phase_reg)
                2'd0: begin sda_oe <= 1'b1; sda_out <= 1'b0; end
                2'd1: scl_out <= 1'b1;
                2'd2: sda_out <= 1'b1;
                default: begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    open_reg <= 1'b0;
                    transmit_empty_flag <= flag_on_done;
                    tx_irq <= 1'b1;
                    state_reg <= S_IDLE;
                end
                endcase
            end
            default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ---- rtl/i2c_tx_defines.vh ----
// Purpose: shared constants for the i2c page write transmitter
// Assumes: 25 MHz system clock
// Notes: definitions only
`ifndef I2C_TX_DEFINES_VH
`define I2C_TX_DEFINES_VH
// status bit positions
`define STAT_TXE_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_NACK_BIT 2
// reset values
`define STAT_TXE_RESET 1'b1
// i2c timing: 100 kHz bus, quarter period in ns
`define CLK_PERIOD_NS 40
`define QUARTER_NS 2500
`define QUARTER_CYCLES (`QUARTER_NS / `CLK_PERIOD_NS)
// fifo shape
`define FIFO_WIDTH 9
`define FIFO_DEPTH 32
`endif

// ---- rtl/tx_fifo.v ----
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, depth is a power of two
// Notes: full and empty derive from a counter, no lookahead
`timescale 1ns/10ps
module tx_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    // honest flags; in_ready is offered, but the page writer leaves it unused
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage has no reset, only pointers and count do
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointer and occupancy update
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ---- verif/i2c_page_writer_properties.sv ----
// Purpose: temporal checks on the page writer ports
// Assumes: one clock; pins seen as wired bus levels
// Notes: owed stop requests are counted in helper logic
`timescale 1ns/10ps
module i2c_page_writer_properties (
    // clock and reset
    input wire clk,
    input wire nrst,
    // firmware side
    input wire tx_write,
    input wire stop_after_write_bit,
    input wire transmit_empty_flag,
    input wire tx_irq,
    input wire bus_busy,
    // bus levels
    input wire scl_in,
    input wire sda_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    reg scl_reg;
    reg sda_reg;
    reg [7:0] pend_reg;
    wire start_ev = scl_in && scl_reg && !sda_in && sda_reg;
    wire stop_ev = scl_in && scl_reg && sda_in && !sda_reg;
    // a counter, not a flag: queued writes may each ask for a stop
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            pend_reg <= 8'h00;
        end else begin
            scl_reg <= scl_in;
            sda_reg <= sda_in;
            pend_reg <= pend_reg + {7'h00, tx_write & stop_after_write_bit}
                - {7'h00, stop_ev};
        end
    end
    sequence s_start;
        start_ev;
    endsequence
    sequence s_stop;
        stop_ev;
    endsequence
    property p_clear_empty;
        tx_write |=> !transmit_empty_flag;
    endproperty
    property p_irq_pulse;
        tx_irq |=> !tx_irq;
    endproperty
    property p_empty_irq;
        $rose(transmit_empty_flag) |-> tx_irq || $past(tx_irq);
    endproperty
    property p_start_first;
        tx_write && !bus_busy && transmit_empty_flag |-> ##[1:1000] s_start;
    endproperty
    property p_stop_irq;
        s_stop |-> ##[0:1000] tx_irq;
    endproperty
    property p_stop_flagged;
        s_stop |-> pend_reg != 8'h00;
    endproperty
    property p_stop_ends;
        s_stop |-> ##[1:1000] (!bus_busy || start_ev);
    endproperty
    a_clear_empty: assert property (p_clear_empty)
        else $error("empty flag high after a write");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");
    a_empty_irq: assert property (p_empty_irq)
        else $error("empty flag set without interrupt");
    a_start_first: assert property (p_start_first)
        else $error("no start after write on idle bus");
    a_stop_irq: assert property (p_stop_irq)
        else $error("no interrupt after stop");
    a_stop_flagged: assert property (p_stop_flagged)
        else $error("stop sent without stop request");
    a_stop_ends: assert property (p_stop_ends)
        else $error("transfer continued after stop");
endmodule

// ---- verif/eeprom_slave_model.sv ----
// Purpose: serial eeprom slave that records every byte it receives
// Assumes: open-drain bus with pull-ups; acks every byte
// Notes: never stretches the clock, as the master cannot follow
`timescale 1ns/10ps
module eeprom_slave_model (
    // bus levels
    input wire scl,
    input wire sda,
    // pull on the data line, released means pulled up
    output reg sda_pull
);
    integer bits = 0;
    integer starts = 0;
    integer stops = 0;
    reg [7:0] sh;
    reg [7:0] got[$];
    initial sda_pull = 1'b0;
    // start: data falls while clock high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            starts++;
            bits = 0;
        end
    end
    // stop: data rises while clock high, only inside an open frame so
    // the settling of the lines at reset is not counted
    always @(posedge sda) begin
        if (scl === 1'b1 && starts > stops)
            stops++;
    end
    // shift msb first; ninth clock is the ack slot
    always @(posedge scl) begin
        if (bits < 8) begin
            sh = {sh[6:0], sda};
            bits++;
            if (bits == 8)
                got.push_back(sh);
        end else
            bits = 0;
    end
    // pull low for the ack slot only, release when clock falls
    always @(negedge scl) sda_pull <= (bits == 8);
endmodule

// ---- verif/i2c_page_writer_tb_top.sv ----
// Purpose: page write and back-to-back byte writes against a slave
// Assumes: quarter period shortened to 2 cycles
// Notes: fifo overflow is not exercised
`timescale 1ns/10ps
module i2c_page_writer_tb_top;
    reg clk = 0, nrst = 0, tx_write = 0, stop_bit = 0, open = 0;
    reg [7:0] tx_byte = 8'h00, addr = 8'ha0;
    wire empty, irq, nack, busy, scl_out, scl_oe, sda_out, sda_oe, pull;
    // an undriven line reads as its pull-up level, also before reset
    wire scl_w = (scl_oe === 1'b1) ? scl_out : 1'b1;
    wire sda_w = ((sda_oe === 1'b1) ? sda_out : 1'b1) & ~(pull === 1'b1);
    integer n_errors = 0, checks_done = 0, seed = 32'h791c;
    integer i, k, n_irq = 0, n_bytes = 0, exp_starts = 0, exp_stops = 0;
    reg [7:0] exp_q[$];
    i2c_page_writer #(.QUARTER(2), .DEPTH(32)) uut (.clk(clk), .nrst(nrst),
        .tx_write(tx_write), .transmit_data_register(tx_byte),
        .slave_address_register(addr), .stop_after_write_bit(stop_bit),
        .transmit_empty_flag(empty), .tx_irq(irq), .nack_seen(nack),
        .bus_busy(busy), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe));
    eeprom_slave_model partner (.scl(scl_w), .sda(sda_w), .sda_pull(pull));
    always #20 clk = ~clk;
    // count completions for the per-byte interrupt tally
    always @(posedge clk) if (irq === 1'b1) n_irq++;
    task check(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one firmware write; the model opens and closes frames as required
    task send(input [7:0] b, input s);
        @(posedge clk);
        tx_write <= 1'b1;
        tx_byte <= b;
        stop_bit <= s;
        if (!open) begin
            exp_q.push_back(addr);
            exp_starts++;
        end
        exp_q.push_back(b);
        n_bytes++;
        exp_stops += s;
        open = !s;
        @(posedge clk);
        tx_write <= 1'b0;
        @(negedge clk);
        check("empty", 0, empty);
    endtask
    task wait_empty;
        for (k = 0; k < 1000 && empty !== 1'b1; k++) @(negedge clk);
        check("empty", 1, empty);
    endtask
    task end_test(input string name);
        // let the last interrupt pulse reach the tally first
        @(negedge clk);
        check("bytes", exp_q.size(), partner.got.size());
        for (k = 0; k < exp_q.size() && k < partner.got.size(); k++)
            check("byte", exp_q[k], partner.got[k]);
        check("starts", exp_starts, partner.starts);
        check("stops", exp_stops, partner.stops);
        check("irqs", n_bytes, n_irq);
        check("nack", 0, nack);
        $display("test %s done", name);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        n_errors++;
        results;
    end
    initial begin
        // clock runs through the whole 60 us reset window
        repeat (1500) @(posedge clk);
        nrst <= 1'b1;
        addr <= $random(seed) & 8'hfe;
        // address byte, 33 held data bytes, then last with stop
        for (i = 0; i < 34; i++) begin
            send($random(seed), i == 33);
            wait_empty;
        end
        end_test("page_write");
        // two single-byte frames queued back to back
        send($random(seed), 1'b1);
        send($random(seed), 1'b1);
        wait_empty;
        end_test("back_to_back");
        results;
    end
endmodule
bind i2c_page_writer i2c_page_writer_properties chk (.clk(clk), .nrst(nrst),
    .tx_write(tx_write), .stop_after_write_bit(stop_after_write_bit),
    .transmit_empty_flag(transmit_empty_flag), .tx_irq(tx_irq),
    .bus_busy(bus_busy), .scl_in(scl_in), .sda_in(sda_in));
